/* rtl/dmart_consts.svh */
`ifndef DMART_CONSTS_SVH
`define DMART_CONSTS_SVH
// register byte offsets
`define DMART_CFG0_OFF 8'h00
`define DMART_CFG1_OFF 8'h04
`define DMART_SRC_OFF 8'h08
`define DMART_DST_OFF 8'h0c
`define DMART_PBOFF_OFF 8'h10
`define DMART_CTRL_OFF 8'h14
`define DMART_STAT_OFF 8'h18
`define DMART_LEFT_OFF 8'h1c
// control bits
`define DMART_CTRL_START 0
`define DMART_CTRL_CLR 1
`define DMART_CTRL_BUFMODE 2
`define DMART_CTRL_UNMASK 3
`define DMART_CTRL_ENABLE 8
`define DMART_CTRL_RST 32'h0000_0000
// descriptor field codes and error bits
`define DMART_BUS_PB 2'h2
`define DMART_INCR_LIN 2'h1
`define DMART_ERR_RETRY 0
`define DMART_ERR_BD 4
// axi responses
`define DMART_OKAY 2'h0
`define DMART_SLVERR 2'h2
`endif

/* rtl/dmart_pkg.sv */
package dmart_pkg;
    // first descriptor configuration word
    typedef struct packed {
        logic buffer_check_enable;
        logic buffer_available;
        logic bd_next;
        logic [1:0] rsv0;
        logic [2:0] subchan;
        logic rsv1;
        logic [1:0] dst_incr;
        logic [2:0] dst_size;
        logic [1:0] dst_bus;
        logic rsv2;
        logic [1:0] src_incr;
        logic [2:0] src_size;
        logic [1:0] src_bus;
        logic [3:0] retry_limit;
        logic self_retry_enable;
        logic lock;
        logic split;
        logic eol;
    } dmart_cfg0_t;
    // what the bus masters are told for the current burst
    typedef struct packed {
        logic active;
        logic split;
        logic phase;
        logic [1:0] src_bus;
        logic [1:0] dst_bus;
        logic [31:0] src_addr;
        logic [31:0] dst_addr;
    } dmart_xfer_t;
    typedef enum logic [1:0] {S_IDLE, S_BURST, S_FROZEN} dmart_state_t;
endpackage

/* rtl/dmart_ctrl.sv */
// How it works
// - without self-retry, retry drops request bit
// - request pin high resumes at retried burst
// - source end-of-data releases bus, reports it
// - end-of-data ends transaction, sets done too
// - clear-done command also clears end-of-data
// - unavailable checked buffer terminates at once
// - unavailable buffer sets error bit four
// - no automatic recovery after descriptor error
// - data moves only in full-width words
// - each descriptor supplies its own sizes
// - counters and addresses wrap in 16 bits
// - same-bus transfers always run split
// - packet buffer starts at channel offset
// - channel numbers stable through each burst
// - self-retry counts, over limit freezes
// - check enable bit 31, available bit 30
`include "dmart_consts.svh"
module dmart_ctrl import dmart_pkg::*; #(
    parameter int BUS_BYTES = 4
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // peripheral handshake pins
    input wire logic dma_req,
    output logic dma_ack,
    // engine events, same clock
    input wire logic eng_retry,
    input wire logic eng_eod,
    input wire logic eng_beat,
    // burst control and tags
    output dmart_xfer_t xfer,
    output logic [3:0] actchan,
    output logic [2:0] subchan,
    output logic chan_error
);
    localparam logic [15:0] STEP = 16'(BUS_BYTES);

    // widest-bus word size must be a power of two from 1 to 16 bytes
    if (BUS_BYTES < 1 || BUS_BYTES > 16 || (BUS_BYTES & (BUS_BYTES - 1)) != 0) begin : g_chk
        $error("dmart_ctrl: BUS_BYTES unsupported");
    end

    dmart_cfg0_t cfg0_q;
    logic [31:0] cfg1_q, src_q, dst_q, pboff_q, ctrl_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic aw_have_q, w_have_q, wfire, wctrl;
    logic req_s1_q, req_s2_q;
    dmart_state_t state_q;
    logic req_q, done_q, eod_q, hw_q, started_q;
    logic [4:0] err_q;
    logic [3:0] retry_cnt_q;
    logic [15:0] xfer_left_q, burst_left_q, xbase_q, bsize_q;
    logic [31:0] sbase_q, dbase_q;
    logic term_eod, term_bd, sw_start, sw_clr, go_split;

    // request pin crosses in from outside the clock domain
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
        end else if (ce) begin
            req_s1_q <= dma_req;
            req_s2_q <= req_s1_q;
        end
    end

    // write side: address and data are taken in either order
    assign wfire = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wctrl = wfire && awaddr_q == `DMART_CTRL_OFF;
    assign sw_start = wctrl && wdata_q[`DMART_CTRL_START];
    assign sw_clr = wctrl && wdata_q[`DMART_CTRL_CLR];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DMART_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            cfg0_q <= '0;
            cfg1_q <= 32'h0000_0000;
            src_q <= 32'h0000_0000;
            dst_q <= 32'h0000_0000;
            pboff_q <= 32'h0000_0000;
            ctrl_q <= `DMART_CTRL_RST;
        end else if (ce) begin
            s_axi_awready <= !aw_have_q && !s_axi_awready ? !s_axi_bvalid : s_axi_awready;
            s_axi_wready <= !w_have_q && !s_axi_wready ? !s_axi_bvalid : s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                s_axi_awready <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                s_axi_wready <= 1'b0;
                wdata_q <= s_axi_wdata;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wfire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= awaddr_q[7:5] == 3'h0 && awaddr_q[1:0] == 2'h0 ? `DMART_OKAY : `DMART_SLVERR;
                // strobes are all-or-nothing: descriptor words are never split
                if (s_axi_wstrb == 4'hf) begin
                    unique case (awaddr_q)
                        `DMART_CFG0_OFF: cfg0_q <= wdata_q;
                        `DMART_CFG1_OFF: cfg1_q <= wdata_q;
                        `DMART_SRC_OFF: src_q <= wdata_q;
                        `DMART_DST_OFF: dst_q <= wdata_q;
                        `DMART_PBOFF_OFF: pboff_q <= wdata_q;
                        `DMART_CTRL_OFF: ctrl_q <= wdata_q & 32'h0000_01fc; // start and clear are pulses
                        default: ;
                    endcase
                end
            end
        end
    end

    // read side: one-cycle answer, unmapped words read zero with an error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `DMART_OKAY;
        end else if (ce) begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `DMART_OKAY;
                unique case (s_axi_araddr)
                    `DMART_CFG0_OFF: s_axi_rdata <= cfg0_q;
                    `DMART_CFG1_OFF: s_axi_rdata <= cfg1_q;
                    `DMART_SRC_OFF: s_axi_rdata <= src_q;
                    `DMART_DST_OFF: s_axi_rdata <= dst_q;
                    `DMART_PBOFF_OFF: s_axi_rdata <= pboff_q;
                    `DMART_CTRL_OFF: s_axi_rdata <= ctrl_q;
                    `DMART_STAT_OFF: s_axi_rdata <= {12'h000, retry_cnt_q, 3'h0, err_q, 4'h0,
                        state_q == S_FROZEN, eod_q, done_q, req_q};
                    `DMART_LEFT_OFF: s_axi_rdata <= {16'h0000, xfer_left_q};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `DMART_SLVERR;
                    end
                endcase
            end
        end
    end

    // termination causes; end-of-data outranks a retry in the same cycle
    assign term_eod = state_q == S_BURST && eng_eod;
    assign term_bd = state_q == S_IDLE && req_q && !started_q && ctrl_q[`DMART_CTRL_BUFMODE]
        && cfg0_q.buffer_check_enable && !cfg0_q.buffer_available;
    assign go_split = cfg0_q.split || cfg0_q.src_bus == cfg0_q.dst_bus;

    // channel engine: status flags, counters and burst sequencing
    always_ff @(posedge aclk) begin
        if (!aresetn || (ce && !ctrl_q[`DMART_CTRL_ENABLE])) begin
            state_q <= S_IDLE;
            req_q <= 1'b0;
            done_q <= 1'b0;
            eod_q <= 1'b0;
            hw_q <= 1'b0;
            started_q <= 1'b0;
            err_q <= 5'h00;
            retry_cnt_q <= 4'h0;
            xfer_left_q <= 16'h0000;
            burst_left_q <= 16'h0000;
            xbase_q <= 16'h0000;
            bsize_q <= 16'h0000;
            sbase_q <= 32'h0000_0000;
            dbase_q <= 32'h0000_0000;
            xfer <= '0;
            actchan <= 4'h0;
            subchan <= 3'h0;
            dma_ack <= 1'b0;
            chan_error <= 1'b0;
        end else if (ce) begin
            chan_error <= |err_q;
            // clears first so that a same-cycle set below wins
            if (sw_clr) begin
                done_q <= 1'b0;
                eod_q <= 1'b0;
            end
            // withdrawing the pin ends the acknowledge and the done state
            if (hw_q && !req_s2_q && !req_q) begin
                hw_q <= 1'b0;
                dma_ack <= 1'b0;
                done_q <= 1'b0;
                eod_q <= 1'b0;
            end
            if (sw_start && state_q == S_IDLE) begin
                req_q <= 1'b1;
            end
            // a high pin starts a transfer, or resumes the retried burst
            if (ctrl_q[`DMART_CTRL_UNMASK] && req_s2_q && state_q == S_IDLE && !req_q && !done_q) begin
                req_q <= 1'b1;
                hw_q <= 1'b1;
            end
            unique case (state_q)
                S_IDLE: begin
                    if (term_bd) begin
                        done_q <= 1'b1;
                        req_q <= 1'b0;
                        err_q[`DMART_ERR_BD] <= 1'b1;
                        dma_ack <= hw_q;
                    end else if (req_q && !started_q) begin
                        // fresh descriptor: sizes come from it alone
                        started_q <= 1'b1;
                        retry_cnt_q <= 4'h0;
                        xfer_left_q <= cfg1_q[15:0];
                        xbase_q <= cfg1_q[15:0];
                        bsize_q <= cfg1_q[31:16];
                        burst_left_q <= cfg1_q[31:16] < cfg1_q[15:0] ? cfg1_q[31:16] : cfg1_q[15:0];
                        sbase_q <= cfg0_q.src_bus == `DMART_BUS_PB ? pboff_q : src_q;
                        dbase_q <= cfg0_q.dst_bus == `DMART_BUS_PB ? pboff_q : dst_q;
                        xfer.src_addr <= cfg0_q.src_bus == `DMART_BUS_PB ? pboff_q : src_q;
                        xfer.dst_addr <= cfg0_q.dst_bus == `DMART_BUS_PB ? pboff_q : dst_q;
                        xfer.phase <= 1'b0;
                    end else if (req_q) begin
                        // tags settle in the cycle the burst starts and stay put through it
                        state_q <= S_BURST;
                        xfer.active <= 1'b1;
                        xfer.split <= go_split;
                        xfer.src_bus <= cfg0_q.src_bus;
                        xfer.dst_bus <= cfg0_q.dst_bus;
                        actchan <= ctrl_q[7:4];
                        subchan <= cfg0_q.subchan;
                    end
                end
                S_BURST: begin
                    if (term_eod) begin
                        state_q <= S_IDLE;
                        xfer.active <= 1'b0;
                        started_q <= 1'b0;
                        done_q <= 1'b1;
                        eod_q <= 1'b1;
                        req_q <= 1'b0;
                        dma_ack <= hw_q;
                    end else if (eng_retry) begin
                        // rewind to the start of the burst being retried
                        state_q <= S_IDLE;
                        xfer.active <= 1'b0;
                        xfer_left_q <= xbase_q;
                        burst_left_q <= bsize_q < xbase_q ? bsize_q : xbase_q;
                        xfer.src_addr <= sbase_q;
                        xfer.dst_addr <= dbase_q;
                        xfer.phase <= 1'b0;
                        if (!cfg0_q.self_retry_enable) begin
                            req_q <= 1'b0;
                        end else if (retry_cnt_q >= cfg0_q.retry_limit) begin
                            state_q <= S_FROZEN;
                            err_q[`DMART_ERR_RETRY] <= 1'b1;
                        end else begin
                            retry_cnt_q <= retry_cnt_q + 4'h1;
                        end
                    end else if (eng_beat) begin
                        // one full-width word per beat; only the low 16 bits count
                        if (cfg0_q.src_incr == `DMART_INCR_LIN && !(xfer.split && xfer.phase)) begin
                            xfer.src_addr[15:0] <= xfer.src_addr[15:0] + STEP;
                        end
                        if (cfg0_q.dst_incr == `DMART_INCR_LIN && !(xfer.split && !xfer.phase)) begin
                            xfer.dst_addr[15:0] <= xfer.dst_addr[15:0] + STEP;
                        end
                        if (!xfer.split || xfer.phase) begin
                            xfer_left_q <= xfer_left_q - STEP;
                        end
                        burst_left_q <= burst_left_q - STEP;
                        if (burst_left_q <= STEP) begin
                            state_q <= S_IDLE;
                            xfer.active <= 1'b0;
                            if (xfer.split && !xfer.phase) begin
                                // source half done, go back round for the destination half
                                xfer.phase <= 1'b1;
                                burst_left_q <= bsize_q < xfer_left_q ? bsize_q : xfer_left_q;
                            end else if (xfer_left_q <= STEP) begin
                                started_q <= 1'b0;
                                req_q <= 1'b0;
                                done_q <= 1'b1;
                                dma_ack <= hw_q;
                            end else begin
                                // new burst base so a retry rewinds only this burst
                                xfer.phase <= 1'b0;
                                xbase_q <= xfer_left_q - STEP;
                                burst_left_q <= bsize_q < xfer_left_q - STEP ? bsize_q : xfer_left_q - STEP;
                                sbase_q <= xfer.split ? xfer.src_addr : {xfer.src_addr[31:16], xfer.src_addr[15:0]
                                    + (cfg0_q.src_incr == `DMART_INCR_LIN ? STEP : 16'h0000)};
                                dbase_q <= {xfer.dst_addr[31:16], xfer.dst_addr[15:0]
                                    + (cfg0_q.dst_incr == `DMART_INCR_LIN ? STEP : 16'h0000)};
                            end
                        end
                    end
                end
                // held until software disables the channel: no recovery of its own
                S_FROZEN: ;
            endcase
        end
    end

    // checks
    eod_sets_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && ctrl_q[`DMART_CTRL_ENABLE] && term_eod |=> done_q && eod_q && !req_q && !xfer.active)
        else $error("end-of-data did not finish the transaction");
    clear_both_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && sw_clr && ctrl_q[`DMART_CTRL_ENABLE] && !term_eod && !term_bd && !eng_beat |=> !eod_q)
        else $error("clear-done left end-of-data set");
    buffer_term_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && ctrl_q[`DMART_CTRL_ENABLE] && term_bd |=> done_q && !req_q && err_q[`DMART_ERR_BD] && state_q == S_IDLE)
        else $error("unavailable buffer not terminated");
    hw_retry_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && ctrl_q[`DMART_CTRL_ENABLE] && state_q == S_BURST && eng_retry && !eng_eod
        && !cfg0_q.self_retry_enable |=> !req_q && !xfer.active)
        else $error("hardware retry kept the request");
    retry_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && ctrl_q[`DMART_CTRL_ENABLE] && state_q == S_BURST && eng_retry && !eng_eod
        && cfg0_q.self_retry_enable && retry_cnt_q >= cfg0_q.retry_limit
        |=> state_q == S_FROZEN && err_q[`DMART_ERR_RETRY])
        else $error("retry limit did not freeze the channel");
    tags_stable_a: assert property (@(posedge aclk) disable iff (!aresetn)
        xfer.active && $past(xfer.active) |-> $stable(actchan) && $stable(subchan))
        else $error("channel tags moved inside a burst");
    addr_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && state_q == S_BURST && eng_beat && !eng_retry && !eng_eod |=> $stable(xfer.src_addr[31:16]))
        else $error("address carried past bit 15");
    early_ack_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && ctrl_q[`DMART_CTRL_ENABLE] && hw_q && (term_eod || term_bd) |=> dma_ack)
        else $error("early termination not acknowledged");
endmodule // dmart_ctrl

/* verif/dmart_eng_model.sv */
module dmart_eng_model import dmart_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // burst control from the channel, commands from the bench
    input wire dmart_xfer_t xfer,
    input wire logic [1:0] mode,
    input wire logic slow,
    // engine events
    output logic eng_beat,
    output logic eng_retry,
    output logic eng_eod
);
    timeunit 1ns;
    timeprecision 1ns;
    logic stall_q;
    // slow mode stalls every other cycle so bursts stretch over the bus
    always_ff @(posedge aclk) begin
        stall_q <= aresetn && slow && !stall_q;
    end
    // one pulse is one full-width word; partial words are never offered
    // slaves here are full width; a narrow one would sit on the low data lanes
    assign eng_beat = xfer.active && mode == 2'h0 && !stall_q;
    // source slave flags end-of-data in the first cycle it owns the bus
    assign eng_eod = xfer.active && mode == 2'h1;
    // retry seen at arbitration; recurs on every resumed burst
    assign eng_retry = xfer.active && mode == 2'h2;
endmodule // dmart_eng_model

/* verif/dmart_ctrl_test.sv */
`include "dmart_consts.svh"
module dmart_ctrl_test import dmart_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    // clock, reset, pins and bus
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, dma_req = 1'b0, dma_ack, chan_error, slow = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, first_src, last_src, last_dst, rd;
    logic [3:0] s_axi_wstrb = 4'hf, actchan;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic eng_beat, eng_retry, eng_eod, act_q = 1'b0, first_split, chan_bad = 1'b0;
    logic [1:0] s_axi_bresp, s_axi_rresp, mode = 2'h0;
    logic [2:0] subchan;
    dmart_xfer_t xfer;
    int err_total = 0, num_checks = 0;

    dmart_ctrl dmart_ctrl_inst (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .dma_req, .dma_ack, .eng_retry, .eng_eod, .eng_beat, .xfer,
        .actchan, .subchan, .chan_error);
    dmart_eng_model dmart_eng_model_inst (.aclk, .aresetn, .xfer, .mode, .slow, .eng_beat,
        .eng_retry, .eng_eod);

    // 10 mhz clock
    initial begin
        forever #50 aclk = ~aclk;
    end

    // capture what each burst shows; tags must not move while the bus is owned
    always @(posedge aclk) begin
        act_q <= xfer.active;
        if (xfer.active && !act_q) begin
            first_src <= xfer.src_addr;
            first_split <= xfer.split;
        end
        if (xfer.active && eng_beat) last_src <= xfer.src_addr;
        if (xfer.active && eng_beat) last_dst <= xfer.dst_addr;
        if (xfer.active && (actchan !== 4'h5 || subchan !== 3'h3)) chan_bad <= 1'b1;
    end

    task automatic wrap_up;
        if (err_total == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // no fixed latency assumed: only the watchdog ends a hung wait
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // status polled until the masked bits match, bounded
    task automatic poll(input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        do begin
            axi_rd(`DMART_STAT_OFF, 2'h0);
            n++;
        end while ((rd & m) !== v && n < 40);
        // a poll that runs out counts as a mismatch
        chk(rd & m, v);
    endtask

    // disabling first resets the channel, so each run starts clean
    task automatic go(input logic [31:0] c0, input logic [31:0] ctl, input logic [1:0] md);
        mode <= md;
        axi_wr(`DMART_CTRL_OFF, 32'h0, 2'h0);
        axi_wr(`DMART_CTRL_OFF, ctl, 2'h0);
        axi_wr(`DMART_CFG0_OFF, c0, 2'h0);
        axi_wr(`DMART_CFG1_OFF, 32'h0008_0010, 2'h0);
        axi_wr(`DMART_SRC_OFF, 32'h0001_fff8, 2'h0);
        axi_wr(`DMART_DST_OFF, 32'h0000_2000, 2'h0);
        axi_wr(`DMART_PBOFF_OFF, 32'h0000_0100, 2'h0);
        axi_wr(`DMART_CTRL_OFF, ctl | 32'h1, 2'h0);
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(`DMART_STAT_OFF, 2'h0);
        chk(rd, 32'h0);
        axi_rd(`DMART_CTRL_OFF, 2'h0);
        chk(rd, `DMART_CTRL_RST);
        axi_rd(8'h20, `DMART_SLVERR);
        chk(rd, 32'h0);
        axi_wr(8'h02, 32'h1, `DMART_SLVERR);
        // two bursts across the 16-bit wrap with a stalling engine
        slow <= 1'b1;
        go(32'h0321_2001, 32'h150, 2'h0);
        // clock enable low holds the engine before its first burst
        ce <= 1'b0;
        repeat (5) @(posedge aclk);
        chk({31'h0, xfer.active}, 32'h0);
        ce <= 1'b1;
        poll(32'h2, 32'h2);
        chk(rd, 32'h2);
        chk(last_src, 32'h0001_0004);
        chk(last_dst, 32'h0000_200c);
        chk({31'h0, first_split}, 32'h0);
        chk({31'h0, chan_bad}, 32'h0);
        slow <= 1'b0;
        // same bus on both sides with the split bit clear
        go(32'h0320_2001, 32'h150, 2'h0);
        poll(32'h2, 32'h2);
        chk({31'h0, first_split}, 32'h1);
        chk(last_dst, 32'h0000_200c);
        // packet buffer as source, split bit clear
        go(32'h0321_0201, 32'h150, 2'h0);
        poll(32'h2, 32'h2);
        chk(first_src, 32'h0000_0100);
        // end-of-data in the first burst, then clear-done
        go(32'h0321_2001, 32'h150, 2'h1);
        poll(32'h2, 32'h2);
        chk(rd, 32'h6);
        axi_wr(`DMART_CTRL_OFF, 32'h152, 2'h0);
        axi_rd(`DMART_STAT_OFF, 2'h0);
        chk(rd, 32'h0);
        // checked buffer marked unavailable
        go(32'h8321_2001, 32'h154, 2'h0);
        poll(32'h2, 32'h2);
        chk(rd, 32'h1002);
        chk({31'h0, chan_error}, 32'h1);
        repeat (20) @(posedge aclk);
        axi_rd(`DMART_STAT_OFF, 2'h0);
        chk(rd, 32'h1002);
        // retry without self-retry, then the request pin resumes
        go(32'h0321_2001, 32'h158, 2'h2);
        poll(32'h1, 32'h0);
        chk(rd, 32'h0);
        mode <= 2'h0;
        dma_req <= 1'b1;
        poll(32'h2, 32'h2);
        chk({31'h0, dma_ack}, 32'h1);
        dma_req <= 1'b0;
        poll(32'h2, 32'h0);
        chk({31'h0, dma_ack}, 32'h0);
        // pin-started transfer cut by end-of-data still acknowledges
        mode <= 2'h1;
        dma_req <= 1'b1;
        poll(32'h6, 32'h6);
        chk({31'h0, dma_ack}, 32'h1);
        dma_req <= 1'b0;
        // self-retry with a limit of one: second retry freezes
        go(32'h0321_2019, 32'h150, 2'h2);
        poll(32'h8, 32'h8);
        chk(rd & 32'hffff_fffe, 32'h0001_0108);
        chk({31'h0, chan_error}, 32'h1);
        wrap_up;
    end

    // the whole run needs a few hundred cycles; a hang ends here
    initial begin
        repeat (30000) @(posedge aclk);
        err_total++;
        wrap_up;
    end
endmodule // dmart_ctrl_test
